//--- pssfc_pkg.sv
// Package: register map, reset values, timing constants and types of the start/stop/fault block
`default_nettype none
package pssfc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] ADDR_STOP_GROUP = 8'h19;
  localparam logic [7:0] ADDR_SOFT_PERIOD = 8'h1a;
  localparam logic [7:0] ADDR_OSC_TRIM = 8'h1b;
  localparam logic [7:0] ADDR_RECOVERY = 8'h1c;

  // ----------------------------------------
  // Reset values and field layout
  // ----------------------------------------
  localparam logic [7:0] RST_STOP_GROUP = 8'h30;
  localparam logic [7:0] RST_SOFT_PERIOD = 8'h0f;
  localparam logic [7:0] RST_RECOVERY = 8'h02;
  localparam logic [7:0] SOFT_WR_MASK = 8'h9f;
  localparam int SOFT_DIS_BIT = 7;
  localparam logic [7:0] TRIM_FIXED = 8'h80;
  localparam int TRIM_DONE_BIT = 6;
  localparam int TRIM_DIS_BIT = 1;
  localparam logic RST_TRIM_DIS = 1'b1;
  localparam logic [3:0] REC_CODE_MIN = 4'h2;
  localparam int CHANNELS = 4;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_US = 100;
  localparam int TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int TRIM_TIME_US = 100;
  localparam int TRIM_CYCLES = (CLK_HZ / 1_000_000) * TRIM_TIME_US;
  localparam int TICKS_W = 18;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [4:0] {
    ST_OFF = 5'h01,
    ST_START = 5'h02,
    ST_RUN = 5'h04,
    ST_STOP = 5'h08,
    ST_FAULT = 5'h10
  } pssfc_state_e;

  typedef struct packed {
    logic all_channel_shutdown;
    logic stop_group_bypass;
    logic power_down_state;
    logic power_stage_fault;
  } pssfc_sys_s;

  typedef struct packed {
    logic [CHANNELS-1:0] channel_run;
    logic [CHANNELS-1:0] channel_half_duty;
    logic power_stage_reset;
    logic soft_transition_active;
  } pssfc_pwm_s;

  // Soft interval in 0.1 ms ticks
  function automatic logic [TICKS_W-1:0] soft_ticks(input logic [4:0] code);
    case (code)
      5'h08: soft_ticks = 18'h000a5;
      5'h09: soft_ticks = 18'h000ef;
      5'h0a: soft_ticks = 18'h0013a;
      5'h0b: soft_ticks = 18'h00194;
      5'h0c: soft_ticks = 18'h0021b;
      5'h0d: soft_ticks = 18'h002bf;
      5'h0e: soft_ticks = 18'h003ae;
      5'h0f: soft_ticks = 18'h004e9;
      5'h10: soft_ticks = 18'h0002e;
      5'h11: soft_ticks = 18'h0018a;
      5'h12: soft_ticks = 18'h00c46;
      5'h13: soft_ticks = 18'h00fc7;
      5'h14: soft_ticks = 18'h0150a;
      5'h15: soft_ticks = 18'h01b77;
      5'h16: soft_ticks = 18'h024d1;
      5'h17: soft_ticks = 18'h03116;
      5'h18: soft_ticks = 18'h04381;
      5'h19: soft_ticks = 18'h06230;
      5'h1a: soft_ticks = 18'h080df;
      5'h1b: soft_ticks = 18'h0a5b1;
      5'h1c: soft_ticks = 18'h0dcec;
      5'h1d: soft_ticks = 18'h1206d;
      5'h1e: soft_ticks = 18'h1829d;
      5'h1f: soft_ticks = 18'h2037c;
      default: soft_ticks = 18'h0002e;
    endcase
  endfunction

  // Recovery wait in 0.1 ms ticks
  function automatic logic [TICKS_W-1:0] recovery_ticks(input logic [3:0] code);
    case (code)
      4'h2: recovery_ticks = 18'h00bae;
      4'h3: recovery_ticks = 18'h0118a;
      4'h4: recovery_ticks = 18'h0175c;
      4'h5: recovery_ticks = 18'h01d38;
      4'h6: recovery_ticks = 18'h02314;
      4'h7: recovery_ticks = 18'h028e6;
      4'h8: recovery_ticks = 18'h02ec2;
      4'h9: recovery_ticks = 18'h03494;
      default: recovery_ticks = 18'h03a70;
    endcase
  endfunction

endpackage
`default_nettype wire

//--- pssfc_interval_timer.sv
// Interval timer counting whole ticks of a fixed number of clock cycles
`default_nettype none
module pssfc_interval_timer
  import pssfc_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [TICKS_W-1:0] ticks,
  input wire logic run,
  output logic busy,
  output logic done
);

  localparam int PRE_W = (TICK_LEN > 1) ? $clog2(TICK_LEN) : 1;
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_LEN - 1);

  initial begin
    if (TICK_LEN < 1) begin
      $error("TICK_LEN must be at least 1");
    end
  end

  logic [PRE_W-1:0] pre;
  logic [TICKS_W-1:0] remaining;
  wire tick_wrap = busy && run && (pre == PRE_LAST);
  wire last_tick = tick_wrap && (remaining <= TICKS_W'(1));

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pre <= '0;
      remaining <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= last_tick && !load;
      if (load) begin
        pre <= '0;
        remaining <= ticks;
        busy <= 1'b1;
      end else if (busy && run) begin
        pre <= tick_wrap ? '0 : pre + PRE_W'(1);
        if (tick_wrap) begin
          remaining <= remaining - TICKS_W'(1);
        end
        if (last_tick) begin
          busy <= 1'b0;
        end
      end
    end
  end

endmodule
`default_nettype wire

//--- pssfc_ctrl.sv
// Start/stop group, soft transition, oscillator trim and fault recovery control
`default_nettype none

// What this block does
// - Stop-group members stay off unless bypassed
// - Four membership bits, channel one at bit zero
// - Soft interval at 50% on shutdown/power-down change
// - Period bit seven disables timer; reserved zero
// - Five-bit code selects interval from table
// - Interval durations are approximate only
// - Trimmed oscillator enables clock rate detection
// - Writing zero to trim applies factory trim
// - Trim disable bit resets to one
// - Read-only done bit shows trim complete
// - Fault resets power stage, waits, restarts unless shut down or powered down
// - Four-bit code selects recovery wait table
// - Recovery register accepts one write per reset
// - Leaving shutdown starts soft-start sequence
module pssfc_ctrl
  import pssfc_pkg::*;
#(
  parameter int TICK_LEN = TICK_CYCLES,
  parameter int TRIM_LEN = TRIM_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire pssfc_sys_s sys,
  output pssfc_pwm_s pwm,
  output logic factory_trim_select,
  output logic rate_detect_enable
);

  localparam int TRIM_W = $clog2(TRIM_LEN + 1);

  initial begin
    if (TRIM_LEN < 1) begin
      $error("TRIM_LEN must be at least 1");
    end
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] stop_group;
  logic [7:0] soft_period;
  logic trim_dis;
  logic trim_done;
  logic [TRIM_W-1:0] trim_cnt;
  logic trim_busy;
  logic [7:0] recovery;
  logic recovery_written;

  wire hit_stop = reg_wr && (reg_addr == ADDR_STOP_GROUP);
  wire hit_soft = reg_wr && (reg_addr == ADDR_SOFT_PERIOD);
  wire hit_trim = reg_wr && (reg_addr == ADDR_OSC_TRIM);
  wire hit_rec = reg_wr && (reg_addr == ADDR_RECOVERY);
  wire rec_code_ok = (reg_wdata[7:4] == 4'h0) && (reg_wdata[3:0] >= REC_CODE_MIN);
  wire rec_accept = hit_rec && !recovery_written && rec_code_ok;
  wire trim_start = hit_trim && !reg_wdata[TRIM_DIS_BIT];
  wire soft_timer_dis = soft_period[SOFT_DIS_BIT];
  wire [7:0] trim_view = TRIM_FIXED | ({7'h00, trim_done} << TRIM_DONE_BIT)
                         | ({7'h00, trim_dis} << TRIM_DIS_BIT);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_group <= RST_STOP_GROUP;
      soft_period <= RST_SOFT_PERIOD;
      recovery <= RST_RECOVERY;
      recovery_written <= 1'b0;
    end else begin
      if (hit_stop) begin
        stop_group <= reg_wdata;
      end
      if (hit_soft) begin
        soft_period <= reg_wdata & SOFT_WR_MASK;
      end
      if (rec_accept) begin
        recovery <= reg_wdata;
        recovery_written <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Oscillator trim handshake
  // ----------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      trim_dis <= RST_TRIM_DIS;
      trim_done <= 1'b0;
      trim_busy <= 1'b0;
      trim_cnt <= '0;
    end else begin
      if (hit_trim) begin
        trim_dis <= reg_wdata[TRIM_DIS_BIT];
      end
      if (trim_start) begin
        trim_busy <= 1'b1;
        trim_done <= 1'b0;
        trim_cnt <= TRIM_W'(TRIM_LEN);
      end else if (hit_trim) begin
        // Completion in the cancel cycle still counts
        trim_busy <= 1'b0;
        trim_done <= trim_busy && (trim_cnt == TRIM_W'(1));
      end else if (trim_busy) begin
        trim_cnt <= trim_cnt - TRIM_W'(1);
        if (trim_cnt == TRIM_W'(1)) begin
          trim_busy <= 1'b0;
          trim_done <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] next_rdata;

  always_comb begin
    case (reg_addr)
      ADDR_STOP_GROUP: next_rdata = stop_group;
      ADDR_SOFT_PERIOD: next_rdata = soft_period;
      ADDR_OSC_TRIM: next_rdata = trim_view;
      ADDR_RECOVERY: next_rdata = recovery;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // ----------------------------------------
  // Start/stop and fault sequencing
  // ----------------------------------------
  pssfc_state_e state;
  pssfc_state_e next_state;
  logic soft_done;
  logic rec_done;

  wire target_on = !sys.all_channel_shutdown && !sys.power_down_state;
  wire state_change = (next_state != state);
  wire soft_load = state_change && (next_state == ST_START || next_state == ST_STOP);
  wire rec_load = state_change && (next_state == ST_FAULT);
  wire soft_run = !soft_timer_dis;
  wire [CHANNELS-1:0] start_mask =
    sys.stop_group_bypass ? {CHANNELS{1'b1}} : ~stop_group[CHANNELS-1:0];

  always_comb begin
    case (state)
      ST_OFF: begin
        if (sys.power_stage_fault) begin
          next_state = ST_FAULT;
        end else if (target_on) begin
          next_state = ST_START;
        end else begin
          next_state = ST_OFF;
        end
      end
      ST_START: begin
        if (sys.power_stage_fault) begin
          next_state = ST_FAULT;
        end else if (!target_on) begin
          next_state = ST_STOP;
        end else if (soft_done) begin
          next_state = ST_RUN;
        end else begin
          next_state = ST_START;
        end
      end
      ST_RUN: begin
        if (sys.power_stage_fault) begin
          next_state = ST_FAULT;
        end else if (!target_on) begin
          next_state = ST_STOP;
        end else begin
          next_state = ST_RUN;
        end
      end
      ST_STOP: begin
        if (sys.power_stage_fault) begin
          next_state = ST_FAULT;
        end else if (target_on) begin
          next_state = ST_START;
        end else if (soft_done) begin
          next_state = ST_OFF;
        end else begin
          next_state = ST_STOP;
        end
      end
      ST_FAULT: begin
        if (rec_done) begin
          next_state = target_on ? ST_START : ST_OFF;
        end else begin
          next_state = ST_FAULT;
        end
      end
      default: next_state = ST_OFF;
    endcase
  end

  pssfc_interval_timer #(
    .TICK_LEN(TICK_LEN)
  ) u_soft_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(soft_load),
    .ticks(soft_ticks(soft_period[4:0])),
    .run(soft_run),
    .busy(),
    .done(soft_done)
  );

  pssfc_interval_timer #(
    .TICK_LEN(TICK_LEN)
  ) u_recovery_timer (
    .clk(clk),
    .reset_n(reset_n),
    .load(rec_load),
    .ticks(recovery_ticks(recovery[3:0])),
    .run(1'b1),
    .busy(),
    .done(rec_done)
  );

  // ----------------------------------------
  // Registered outputs
  // ----------------------------------------
  pssfc_pwm_s next_pwm;
  wire in_soft = (next_state == ST_START) || (next_state == ST_STOP);

  assign next_pwm.channel_run = (next_state == ST_RUN) ? start_mask : '0;
  assign next_pwm.channel_half_duty = in_soft ? start_mask : '0;
  assign next_pwm.power_stage_reset = (next_state == ST_FAULT);
  assign next_pwm.soft_transition_active = in_soft;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ST_OFF;
      pwm <= '0;
      factory_trim_select <= 1'b0;
      rate_detect_enable <= 1'b0;
    end else begin
      state <= next_state;
      pwm <= next_pwm;
      factory_trim_select <= !trim_dis;
      rate_detect_enable <= trim_done;
    end
  end

endmodule
`default_nettype wire

//--- pssfc_chk_assertions.sv
// Checker of the start/stop/fault control block
`default_nettype none
module pssfc_chk
  import pssfc_pkg::*;
#(
  parameter int TRIM_LEN = TRIM_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire pssfc_sys_s sys,
  input wire pssfc_pwm_s pwm,
  input wire logic factory_trim_select,
  input wire logic rate_detect_enable
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  // ----------------------------------------
  // Shadow of stop group and trim age
  // ----------------------------------------
  logic [3:0] grp;
  logic [15:0] trim_cnt;
  wire logic grp_wr = reg_wr && reg_addr == ADDR_STOP_GROUP;
  wire logic trim_go = reg_wr && reg_addr == ADDR_OSC_TRIM && !reg_wdata[TRIM_DIS_BIT];
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grp <= RST_STOP_GROUP[3:0];
      trim_cnt <= 16'h0000;
    end else begin
      grp <= grp_wr ? reg_wdata[3:0] : grp;
      trim_cnt <= trim_go ? 16'h0001 : trim_cnt + 16'h0001;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_group_kept_off: assert property (!$past(sys.stop_group_bypass) |->
    ((pwm.channel_run | pwm.channel_half_duty) & $past(grp)) == 4'h0)
    else $error("Stop group channel driven");
  a_exit_soft_start: assert property ($fell(sys.all_channel_shutdown) &&
    !sys.power_down_state && !sys.power_stage_fault && !pwm.power_stage_reset
    |=> pwm.soft_transition_active) else $error("No soft start on exit");
  a_pd_soft_change: assert property (!sys.all_channel_shutdown &&
    !$past(sys.all_channel_shutdown) &&
    $changed(sys.power_down_state) && !sys.power_stage_fault && !pwm.power_stage_reset
    |=> pwm.soft_transition_active) else $error("No soft interval on power-down change");
  a_fault_reset: assert property ($rose(sys.power_stage_fault) |=>
    pwm.power_stage_reset [*8]) else $error("Fault did not hold stage reset");
  a_fault_halts: assert property (pwm.power_stage_reset |-> pwm.channel_run == 4'h0 &&
    pwm.channel_half_duty == 4'h0 && !pwm.soft_transition_active)
    else $error("Activity during stage reset");
  a_trim_select: assert property (reg_wr && reg_addr == ADDR_OSC_TRIM |-> ##2
    factory_trim_select == !$past(reg_wdata[TRIM_DIS_BIT], 2)) else $error("Trim select wrong");
  a_trim_time: assert property ($rose(rate_detect_enable) |->
    trim_cnt == 16'(TRIM_LEN + 2)) else $error("Trim completion time wrong");
  a_run_not_half: assert property (pwm.channel_run != 4'h0 |->
    pwm.channel_half_duty == 4'h0 && !pwm.soft_transition_active)
    else $error("Run and half duty together");
  c_all_run: cover property (pwm.channel_run == 4'hf);
  c_fault: cover property ($rose(pwm.power_stage_reset));
  c_trim: cover property ($rose(rate_detect_enable));
endmodule
bind pssfc_ctrl pssfc_chk #(.TRIM_LEN(TRIM_LEN)) i_pssfc_chk (
  .clk(clk), .reset_n(reset_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sys(sys),
  .pwm(pwm), .factory_trim_select(factory_trim_select),
  .rate_detect_enable(rate_detect_enable));
`default_nettype wire

//--- pssfc_host.sv
// Host controller model on the register port
`default_nettype none
module pssfc_host
  import pssfc_pkg::*;
(
  input wire logic clk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // Released lines show inverted values
  task automatic idle();
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
  endtask
  // Recovery register written once, legal code unless a test refuses on purpose
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1;
    idle();
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1;
    d = reg_rdata;
    v = reg_rvalid;
    idle();
  endtask
endmodule
`default_nettype wire

//--- test_pssfc_ctrl.sv
// Self-checking bench of the start/stop/fault control block
`default_nettype none
module test_pssfc_ctrl
  import pssfc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 2;
  localparam int TRIM = 5;
  localparam int SOFT = 46 * TICK;
  localparam int REC = 7480 * TICK;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic reg_wr, reg_rd, reg_rvalid, factory_trim_select, rate_detect_enable;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  pssfc_sys_s sys = pssfc_sys_s'(4'b1000);
  pssfc_pwm_s pwm;
  int fail_count = 0;
  int n_checks = 0;
  int mreg[4] = '{48, 15, 130, 2};
  bit rec_done = 0;
  initial begin
    forever #5 clk = ~clk;
  end
  pssfc_ctrl #(.TICK_LEN(TICK), .TRIM_LEN(TRIM)) i_pssfc_ctrl (.clk(clk), .reset_n(reset_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .sys(sys), .pwm(pwm),
    .factory_trim_select(factory_trim_select), .rate_detect_enable(rate_detect_enable));
  pssfc_host i_pssfc_host (.clk(clk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
  // ----------------------------------------
  // Checking and reference model
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_pssfc_host.wr(a, d);
    if (a == ADDR_SOFT_PERIOD) d = d & 8'h9f;
    if (a == ADDR_OSC_TRIM) d = 8'h80 | (d & 8'h02);
    if (a == ADDR_RECOVERY) begin
      if (rec_done || d > 8'h0f || d < 8'h02) d = 8'(mreg[3]);
      else rec_done = 1;
    end
    if (a >= 8'h19 && a <= 8'h1c) mreg[a - 8'h19] = d;
  endtask
  task automatic rdck(input logic [7:0] a);
    logic [7:0] v;
    logic ok;
    i_pssfc_host.rd(a, v, ok);
    chk("rvalid", 16'(ok), 16'h0001);
    chk($sformatf("reg_%h", a), 16'(v), (a >= 8'h19 && a <= 8'h1c) ? 16'(mreg[a - 8'h19]) : 0);
  endtask
  task automatic setsys(input logic [3:0] v);
    @(posedge clk);
    #1;
    sys = pssfc_sys_s'(v);
  endtask
  function automatic logic hit(input int m);
    case (m)
      0: hit = pwm.channel_run != 4'h0;
      1: hit = pwm.channel_run == 4'h0 && pwm.channel_half_duty == 4'h0;
      default: hit = pwm.soft_transition_active;
    endcase
  endfunction
  task automatic waitc(input int m, input int lo, input int hi, input string nm);
    int n;
    n = 0;
    while (hit(m) !== 1'b1 && n <= hi) begin
      @(posedge clk);
      #2;
      n++;
    end
    chk(nm, 16'((n >= lo && n <= hi) ? lo : n), 16'(lo));
  endtask
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    #(40000 * 10);
    fail_count++;
    end_of_test();
  end
  initial begin
    logic [7:0] a;
    a = 8'($urandom(55));
    repeat (8) @(posedge clk);
    #1 reset_n = 1'b1;
    for (int i = 8'h18; i <= 8'h1d; i++) rdck(8'(i));
    $display("Test reset values done");
    wr(ADDR_OSC_TRIM, 8'h00);
    @(posedge clk);
    #1;
    chk("trim_sel", 16'(factory_trim_select), 16'h0001);
    rdck(ADDR_OSC_TRIM);
    repeat (TRIM) @(posedge clk);
    mreg[2] = 8'hc0;
    rdck(ADDR_OSC_TRIM);
    chk("rate_det", 16'(rate_detect_enable), 16'h0001);
    wr(ADDR_OSC_TRIM, 8'h02);
    @(posedge clk);
    #1;
    chk("trim_sel", 16'(factory_trim_select), 16'h0000);
    $display("Test trim done");
    repeat (8) begin
      a = 8'h19 + 8'($urandom % 2);
      wr(a, 8'($urandom));
      rdck(a);
    end
    foreach (mreg[i]) a = 8'h00;
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_RECOVERY, (i == 2) ? 8'h05 : (i == 1) ? 8'h35 : 8'(i * 4 + 1));
      rdck(ADDR_RECOVERY);
    end
    $display("Test registers done");
    wr(ADDR_STOP_GROUP, 8'h3a);
    wr(ADDR_SOFT_PERIOD, 8'h10);
    setsys(4'b0000);
    @(posedge clk);
    #2;
    chk("half", 16'(pwm.channel_half_duty), 16'h0005);
    waitc(0, SOFT, SOFT + 1, "start_len");
    chk("run", 16'(pwm.channel_run), 16'h0005);
    setsys(4'b0010);
    waitc(1, SOFT + 1, SOFT + 2, "stop_len");
    setsys(4'b0100);
    waitc(0, SOFT + 1, SOFT + 2, "start_all");
    chk("run", 16'(pwm.channel_run), 16'h000f);
    wr(ADDR_SOFT_PERIOD, 8'hf0);
    rdck(ADDR_SOFT_PERIOD);
    setsys(4'b1100);
    repeat (3 * SOFT) @(posedge clk);
    #2;
    chk("held", 16'(pwm.channel_half_duty), 16'h000f);
    wr(ADDR_SOFT_PERIOD, 8'h10);
    waitc(1, 1, SOFT + 2, "stop_resume");
    setsys(4'b0100);
    waitc(0, SOFT + 1, SOFT + 2, "restart");
    $display("Test sequencer done");
    setsys(4'b0101);
    setsys(4'b0100);
    chk("stage_rst", 16'(pwm.power_stage_reset), 16'h0001);
    chk("run", 16'(pwm.channel_run), 16'h0000);
    waitc(2, REC - 1, REC + 2, "recovery");
    $display("Test fault done");
    @(posedge clk);
    #1 reset_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 reset_n = 1'b1;
    mreg = '{48, 15, 130, 2};
    rec_done = 0;
    chk("pwm_rst", 16'(pwm), 16'h0000);
    for (int i = 8'h19; i <= 8'h1c; i++) rdck(8'(i));
    wr(ADDR_RECOVERY, 8'h03);
    rdck(ADDR_RECOVERY);
    $display("Test second reset done");
    end_of_test();
  end
endmodule
`default_nettype wire
